// ===== rtl/uip_core.sv
// Purpose: interrupt mask, generation, clearing and priority encode of a fifo uart
// Assumes: reg_rd and reg_wr are one-cycle strobes on clk; evt inputs on clk
// Notes:   cts_n_pin is asynchronous and filtered through three flops
// Operation
// [R1] fifo mode: receive interrupt follows fifo level at or above trigger
// [R2] data-ready flag set on char load, reset on fifo empty (line logic)
// [R3] host polls line status with fifos on and low mask bits clear
// [R4] line status bits supplied by receiver and transmitter, read here on a line status read
// [R5] mask bit 0 enables receive interrupt, holding reg or trigger level
// [R6] mask bit 1 enables transmit-ready; fires at once if already empty
// [R7] transmit-ready clears on cause read or holding write; rearms on refill
// [R8] mask bit 2: line status bits 1..4 raise interrupt on rising
// [R9] mask bit 3: modem deltas raise interrupt, modem status read clears
// [R10] mask bits 7..4 writable only with enhanced features on
// [R11] mask bits 6 and 7: rts or cts rising during auto flow control
// [R12] modem status read clears rts and cts change interrupts
// [R13] timeout after four chars plus twelve bits, clears when fifo empty
// [R14] line status read clears line interrupt; flags remain outside
// [R15] xoff clears by cause read or xon; special by read or next char
// [R16] cause read reports highest pending only; others stay queued
// [R17] cause bits 5..0 hold the priority code table
// [R18] cause bit 0 low when pending, high when idle and at reset
// [R19] cause bits 7..6 mirror fifo enable
// [R20] auto rs485 mode: transmit-ready on transmitter fully empty
// [R21] interrupt output active whenever any enabled source is pending
`include "uip_regs.svh"
module uip_core
  import uip_pkg::*;
#(
  parameter int TMO_W = 8
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire uip_evt_t   evt,
  input  wire uip_cfg_t   cfg,
  input  wire logic [3:0] char_bits,
  input  wire logic       rts_n_out,
  input  wire logic       cts_n_pin,
  output logic      [7:0] mask_q,
  output logic            irq
);
  // elaboration check: the widest load, fifteen-bit frames, needs seven bits
  if (TMO_W < 7) begin : g_tmo_w_check
    $error("TMO_W too small for timeout load");
  end

  // priority encode, shared by read path and pending flag
  function automatic logic [5:0] uip_encode(input uip_src_t s);
    if (s.ls)       uip_encode = `UIP_CODE_LS;
    else if (s.tmo) uip_encode = `UIP_CODE_TMO;
    else if (s.rx)  uip_encode = `UIP_CODE_RX;
    else if (s.tx)  uip_encode = `UIP_CODE_TX;
    else if (s.ms)  uip_encode = `UIP_CODE_MS;
    else if (s.xs)  uip_encode = `UIP_CODE_XOFF;
    else if (s.fc)  uip_encode = `UIP_CODE_FC;
    else            uip_encode = `UIP_CODE_NONE;
  endfunction

  logic [7:0]       mask_d;
  logic             ls_q, ls_d, tmo_q, tmo_d, tx_q, tx_d, ms_q, ms_d;
  logic             xoff_q, xoff_d, spc_q, spc_d, rts_q, rts_d, cts_q, cts_d;
  logic [3:0]       lerr_prev_q;
  logic             txc_prev_q, rts_prev_q, cts_prev_q;
  logic [2:0]       cts_sync_q;
  logic             cts_filt_q, cts_filt_d;
  logic [TMO_W-1:0] tmo_cnt_q, tmo_cnt_d;
  logic [7:0]       rdata_d;
  logic             irq_d;

  // address decode
  wire logic wr_mask  = reg_wr && (reg_addr == `UIP_ADDR_MASK);
  wire logic wr_data  = reg_wr && (reg_addr == `UIP_ADDR_DATA);
  wire logic rd_cause = reg_rd && (reg_addr == `UIP_ADDR_CAUSE);
  wire logic rd_lsr   = reg_rd && (reg_addr == `UIP_ADDR_LSR);
  wire logic rd_msr   = reg_rd && (reg_addr == `UIP_ADDR_MSR);
  wire logic rd_data  = reg_rd && (reg_addr == `UIP_ADDR_DATA);
  wire logic rd_mask  = reg_rd && (reg_addr == `UIP_ADDR_MASK);

  // high mask bits kept unless enhanced features are on
  wire logic [7:0] wr_keep = cfg.enh_en ? 8'h00 : ~`UIP_MASK_LOW; // R10
  assign mask_d = wr_mask ? ((reg_wdata & ~wr_keep) | (mask_q & wr_keep)) : mask_q;

  // transmit-ready condition depends on mode
  wire logic tx_cond = cfg.rs485_auto ? evt.tx_all_empty :              // R20
                       cfg.fifo_en    ? evt.tx_below_trig : evt.thr_empty; // R6
  wire logic tx_arm  = wr_mask && reg_wdata[`UIP_MASK_TX] && !mask_q[`UIP_MASK_TX]
                       && tx_cond; // R6
  // receive level source needs no latch: it is a plain level
  wire logic rx_lvl  = cfg.fifo_en ? evt.rx_at_trigger : !evt.rx_empty; // R1 R5

  // enabled sources; timeout only in fifo use, special/xoff in either mode
  uip_src_t src;
  assign src.ls  = ls_q  && mask_q[`UIP_MASK_LS];             // R8
  assign src.tmo = tmo_q && mask_q[`UIP_MASK_RX];             // R13
  assign src.rx  = rx_lvl && mask_q[`UIP_MASK_RX];            // R1 R5
  assign src.tx  = tx_q  && mask_q[`UIP_MASK_TX];             // R6
  assign src.ms  = ms_q  && mask_q[`UIP_MASK_MS];             // R9
  assign src.xs  = (xoff_q || spc_q) && mask_q[`UIP_MASK_XOFF]; // R15
  assign src.fc  = (rts_q && mask_q[`UIP_MASK_RTS]) ||
                   (cts_q && mask_q[`UIP_MASK_CTS]);           // R11
  wire logic [5:0] code = uip_encode(src); // R16 R17
  wire logic       tx_top = (code == `UIP_CODE_TX);
  wire logic       xs_top = (code == `UIP_CODE_XOFF);

  // sticky flags, a set in the clearing cycle wins
  wire logic [3:0] lerr_rise = evt.line_err & ~lerr_prev_q;
  assign ls_d   = (|lerr_rise) || (ls_q && !rd_lsr);                  // R8 R14
  assign tx_d   = (tx_cond && !txc_prev_q) || tx_arm ||
                  (tx_q && !(rd_cause && tx_top) && !wr_data);        // R7
  assign ms_d   = (|evt.modem_delta) || (ms_q && !rd_msr);            // R9
  assign xoff_d = evt.xoff_det || (xoff_q && !(rd_cause && xs_top) && !evt.xon_det); // R15
  assign spc_d  = evt.special_det ||
                  (spc_q && !(rd_cause && xs_top) && !evt.rx_char_loaded); // R15
  assign rts_d  = (cfg.auto_rts && rts_n_out && !rts_prev_q) || (rts_q && !rd_msr); // R11 R12
  assign cts_d  = (cfg.auto_cts && cts_filt_q && !cts_prev_q) || (cts_q && !rd_msr); // R11 R12

  // pin filter: level changes when second and third stages agree
  assign cts_filt_d = (cts_sync_q[1] == cts_sync_q[2]) ? cts_sync_q[2] : cts_filt_q;

  // timeout load figure, restarted by each char loaded or read
  wire logic [TMO_W-1:0] tmo_load =
    TMO_W'(char_bits) * TMO_W'(`UIP_TMO_CHARS) + TMO_W'(`UIP_TMO_EXTRA_BITS);
  wire logic tmo_restart = evt.rx_char_loaded || rd_data;
  wire logic tmo_fire = cfg.fifo_en && !evt.rx_empty && evt.bit_tick && !tmo_restart
                        && (tmo_cnt_q == TMO_W'(1)); // R13
  always_comb begin
    tmo_cnt_d = tmo_cnt_q;
    if (tmo_restart || evt.rx_empty) tmo_cnt_d = tmo_load;
    else if (evt.bit_tick && tmo_cnt_q != '0) tmo_cnt_d = tmo_cnt_q - TMO_W'(1);
  end
  // timeout holds until fifo drained; firing wins
  assign tmo_d = tmo_fire || (tmo_q && !evt.rx_empty); // R13

  // read data: cause snapshots the top source at the read edge
  wire logic [7:0] cause_val = {cfg.fifo_en, cfg.fifo_en, code}; // R18 R19
  // line status view; bit 7 approximated from the error at the read position
  wire logic [7:0] lsr_val = {|evt.line_err, evt.tx_all_empty, evt.thr_empty,
                              evt.line_err, !evt.rx_empty}; // R2 R4
  assign rdata_d = rd_cause ? cause_val :
                   rd_mask  ? mask_q    :
                   rd_lsr   ? lsr_val   : 8'h00;
  assign irq_d   = (code != `UIP_CODE_NONE); // R21

  // mask register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mask_q <= `UIP_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // line status flag
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ls_q <= 1'b0;
    end else begin
      ls_q <= ls_d;
    end
  end

  // receive timeout flag
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tmo_q <= 1'b0;
    end else begin
      tmo_q <= tmo_d;
    end
  end

  // transmit-ready flag
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
    end
  end

  // modem status flag
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ms_q <= 1'b0;
    end else begin
      ms_q <= ms_d;
    end
  end

  // xoff and special character flags
  always_ff @(posedge clk) begin
    if (!resetn) begin
      xoff_q <= 1'b0;
      spc_q  <= 1'b0;
    end else begin
      xoff_q <= xoff_d;
      spc_q  <= spc_d;
    end
  end

  // flow control change flags
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rts_q <= 1'b0;
      cts_q <= 1'b0;
    end else begin
      rts_q <= rts_d;
      cts_q <= cts_d;
    end
  end

  // edge history; rts and cts start at their idle high so reset makes no false rise
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lerr_prev_q <= 4'h0;
      txc_prev_q  <= 1'b0;
      rts_prev_q  <= 1'b1;
      cts_prev_q  <= 1'b1;
    end else begin
      lerr_prev_q <= evt.line_err;
      txc_prev_q  <= tx_cond;
      rts_prev_q  <= rts_n_out;
      cts_prev_q  <= cts_filt_q;
    end
  end

  // cts pin synchroniser and filter, idle high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cts_sync_q <= 3'h7;
      cts_filt_q <= 1'b1;
    end else begin
      cts_sync_q <= {cts_sync_q[1:0], cts_n_pin};
      cts_filt_q <= cts_filt_d;
    end
  end

  // timeout counter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tmo_cnt_q <= '0;
    end else begin
      tmo_cnt_q <= tmo_cnt_d;
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      irq       <= 1'b0;
    end else begin
      reg_rdata <= rdata_d;
      irq       <= irq_d;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_IRQ_FOLLOWS: assert property (irq_d |=> irq)  // R21
    else $error("irq not raised after pending source");
  AST_CAUSE_BIT0: assert property (rd_cause |=> reg_rdata[0] == !irq) // R18
    else $error("cause bit 0 disagrees with irq");
  AST_FIFO_BITS: assert property (rd_cause |=> reg_rdata[7:6] == {2{$past(cfg.fifo_en)}}) // R19
    else $error("cause fifo bits wrong");
  AST_TX_ARM: assert property (tx_arm |=> tx_q) // R6
    else $error("transmit-ready not armed on enable");
  AST_TX_CLR: assert property (wr_data && !(tx_cond && !txc_prev_q) && !tx_arm |=> !tx_q) // R7
    else $error("holding write did not clear transmit-ready");
  AST_LS_SET: assert property (|lerr_rise |=> ls_q) // R8
    else $error("line status rise not latched");
  AST_LS_CLR: assert property (rd_lsr && !(|lerr_rise) |=> !ls_q) // R14
    else $error("line status read did not clear");
  AST_MS_CLR: assert property (rd_msr && !(|evt.modem_delta) |=> !ms_q) // R9
    else $error("modem status read did not clear");
  AST_FC_CLR: assert property (rd_msr && !cfg.auto_rts && !cfg.auto_cts |=> !rts_q && !cts_q) // R12
    else $error("flow change not cleared by modem read");
  AST_HIGH_MASK: assert property (wr_mask && !cfg.enh_en |=> mask_q[7:4] == $past(mask_q[7:4])) // R10
    else $error("high mask bits written without enhanced features");
  AST_TMO_CLR: assert property (tmo_q && evt.rx_empty |=> !tmo_q) // R13
    else $error("timeout not cleared on empty fifo");
  AST_LS_TOP: assert property (src.ls |-> code == `UIP_CODE_LS) // R16 R17
    else $error("line status not top priority");
  AST_XON_CLR: assert property (xoff_q && evt.xon_det && !evt.xoff_det |=> !xoff_q) // R15
    else $error("xon did not clear xoff");
  AST_MS_SET: assert property (|evt.modem_delta |=> ms_q) // R9
    else $error("modem delta not latched");
  AST_XOFF_SET: assert property (evt.xoff_det |=> xoff_q) // R15
    else $error("xoff not latched");
  AST_SPC_CLR: assert property (spc_q && evt.rx_char_loaded && !evt.special_det |=> !spc_q) // R15
    else $error("next char did not clear special");
  AST_TX_READ_CLR: assert property (rd_cause && tx_top && !(tx_cond && !txc_prev_q) |=> !tx_q) // R7
    else $error("cause read did not clear transmit-ready");
  AST_TMO_SET: assert property (tmo_fire |=> tmo_q) // R13
    else $error("timeout not latched");
  AST_RX_LEVEL: assert property (src.rx && !src.ls && !src.tmo |-> code == `UIP_CODE_RX) // R1 R16
    else $error("receive source not reported");
  AST_CTS_RISE: assert property (cfg.auto_cts && cts_filt_q && !cts_prev_q |=> cts_q) // R11
    else $error("cts rise not latched");
  AST_LSR_BIT0: assert property (rd_lsr |=> reg_rdata[0] != $past(evt.rx_empty)) // R2
    else $error("data ready bit wrong");

  COV_TMO: cover property (tmo_fire ##1 tmo_q);
  COV_TX_READ: cover property (tx_q && rd_cause && tx_top ##1 !tx_q);
  COV_TWO_PENDING: cover property (src.ls && src.rx ##1 rd_lsr ##1 src.rx);
  COV_CTS: cover property (cts_d && !cts_q);
  COV_RS485_TX: cover property (cfg.rs485_auto && tx_cond && !txc_prev_q);
endmodule // uip_core

// ===== rtl/uip_regs.svh
// Purpose: register addresses, field positions and codes of the interrupt prioritizer
// Assumes: register port uses three address bits, as on the uart bus
// Notes:   addresses follow the usual uart register map
`ifndef UIP_REGS_SVH
`define UIP_REGS_SVH
`define UIP_ADDR_DATA      3'h0
`define UIP_ADDR_MASK      3'h1
`define UIP_ADDR_CAUSE     3'h2
`define UIP_ADDR_LSR       3'h5
`define UIP_ADDR_MSR       3'h6
`define UIP_MASK_RST       8'h00
`define UIP_MASK_LOW       8'h0F
`define UIP_MASK_RX        0
`define UIP_MASK_TX        1
`define UIP_MASK_LS        2
`define UIP_MASK_MS        3
`define UIP_MASK_XOFF      5
`define UIP_MASK_RTS       6
`define UIP_MASK_CTS       7
`define UIP_CODE_LS        6'h06
`define UIP_CODE_TMO       6'h0C
`define UIP_CODE_RX        6'h04
`define UIP_CODE_TX        6'h02
`define UIP_CODE_MS        6'h00
`define UIP_CODE_XOFF      6'h10
`define UIP_CODE_FC        6'h20
`define UIP_CODE_NONE      6'h01
`define UIP_TMO_CHARS      4
`define UIP_TMO_EXTRA_BITS 12
`endif

// ===== rtl/uip_pkg.sv
// Purpose: types shared by the interrupt prioritizer
// Assumes: event inputs come from logic on the same clock
// Notes:   one-cycle pulses unless named as a level
package uip_pkg;
  typedef struct packed {
    logic       rx_char_loaded; // pulse: char moved from shift reg into fifo
    logic       rx_empty;       // level: receive fifo or holding reg empty
    logic       rx_at_trigger;  // level: fifo level at or above trigger
    logic [3:0] line_err;       // level: line status bits 4..1
    logic       thr_empty;      // level: holding reg empty
    logic       tx_below_trig;  // level: tx fifo below trigger or empty
    logic       tx_all_empty;   // level: tx fifo and shift reg empty
    logic [3:0] modem_delta;    // pulse: modem status bits 3..0 set
    logic       xoff_det;       // pulse
    logic       xon_det;        // pulse
    logic       special_det;    // pulse
    logic       bit_tick;       // pulse: one per receive bit time
  } uip_evt_t;
  typedef struct packed {
    logic fifo_en;      // fifo enable
    logic enh_en;       // enhanced features enabled
    logic rs485_auto;   // auto direction control
    logic auto_rts;     // automatic rts flow control
    logic auto_cts;     // automatic cts flow control
  } uip_cfg_t;
  typedef struct packed {
    logic ls;
    logic tmo;
    logic rx;
    logic tx;
    logic ms;
    logic xs;
    logic fc;
  } uip_src_t;
endpackage

// ===== bench/uip_host_model.sv
// Purpose: host side of the register port, one access at a time
// Assumes: strobes change on the falling edge; read data taken half a cycle after the read edge
// Notes:   idle address and data show the inverse of the last value, never a stale copy
module uip_host_model (
  input  wire logic       clk,
  output logic      [2:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idles with no strobe at time zero
  initial begin
    reg_addr  = 3'h7;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'hA5;
  end
  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // read data stands one cycle only, so take it at the next falling edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule // uip_host_model

// ===== bench/test_uart_interrupt_prioritizer.sv
// Purpose: self-checking bench of the interrupt prioritizer
// Assumes: inputs change on the falling edge; cts pin raised once
// Notes:   level sources and transmit-ready go through a row table, other latched sources by hand
`include "uip_regs.svh"
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module test_uart_interrupt_prioritizer import uip_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] mask;
    logic       fifo;
    logic       trig;
    logic       empty;
    logic       txb;
    logic [7:0] cause;
  } uip_row_t;
  logic       clk;
  logic       resetn;
  logic [2:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  uip_evt_t   evt;
  uip_cfg_t   cfg;
  logic [3:0] char_bits;
  logic       rts_n_out;
  logic       cts_n_pin;
  logic [7:0] mask_q;
  logic       irq;
  logic [7:0] v;
  int         err_count = 0;
  int         n_tests = 0;
  uip_row_t   rows[6] = '{
    '{8'h00, 1'b1, 1'b1, 1'b0, 1'b0, 8'hC1},
    '{8'h01, 1'b1, 1'b1, 1'b0, 1'b0, 8'hC4},
    '{8'h01, 1'b1, 1'b0, 1'b0, 1'b0, 8'hC1},
    '{8'h01, 1'b0, 1'b0, 1'b0, 1'b0, 8'h04},
    '{8'h03, 1'b1, 1'b1, 1'b0, 1'b1, 8'hC4},
    '{8'h02, 1'b1, 1'b0, 1'b1, 1'b1, 8'hC2}};
  uip_core uip_core_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .evt(evt), .cfg(cfg),
    .char_bits(char_bits), .rts_n_out(rts_n_out), .cts_n_pin(cts_n_pin), .mask_q(mask_q),
    .irq(irq));
  uip_host_model uip_host_model_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // verdict in one place, reached by the tests or the watchdog
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // read the cause register and compare, irq must agree with bit 0
  task automatic cause_is(input logic [7:0] exp);
    repeat (2) @(negedge clk);
    `CHK("irq", ~exp[0], irq)
    uip_host_model_inst.rd(`UIP_ADDR_CAUSE, v);
    `CHK("cause", exp, v)
  endtask
  // a whole run is under two hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    resetn = 1'b0;
    evt = '0;
    evt.rx_empty = 1'b1;
    cfg = '0;
    char_bits = 4'h1;
    rts_n_out = 1'b0;
    cts_n_pin = 1'b0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    `CHK("mask_q", 8'h00, mask_q)
    cause_is(8'h01);
    $display("test reset done");
    foreach (rows[i]) begin
      cfg.fifo_en = rows[i].fifo;
      evt.rx_at_trigger = rows[i].trig;
      evt.rx_empty = rows[i].empty;
      evt.tx_below_trig = rows[i].txb;
      evt.thr_empty = rows[i].txb;
      uip_host_model_inst.wr(`UIP_ADDR_MASK, rows[i].mask);
      cause_is(rows[i].cause);
    end
    cause_is(8'hC1);
    evt.tx_below_trig = 1'b0;
    @(negedge clk);
    evt.tx_below_trig = 1'b1;
    cause_is(8'hC2);
    evt.tx_below_trig = 1'b0;
    @(negedge clk);
    evt.tx_below_trig = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("irq tx", 1'b1, irq)
    uip_host_model_inst.wr(`UIP_ADDR_DATA, 8'h5A);
    cause_is(8'hC1);
    $display("test table and tx done");
    evt.rx_empty = 1'b1;
    uip_host_model_inst.wr(`UIP_ADDR_MASK, 8'hF0);
    uip_host_model_inst.rd(`UIP_ADDR_MASK, v);
    `CHK("mask locked", 8'h00, v)
    cfg.enh_en = 1'b1;
    uip_host_model_inst.wr(`UIP_ADDR_MASK, 8'h6C);
    `CHK("mask_q", 8'h6C, mask_q)
    $display("test mask lock done");
    evt.line_err = 4'h1;
    evt.modem_delta = 4'h2;
    @(negedge clk);
    evt.modem_delta = 4'h0;
    cause_is(8'hC6);
    uip_host_model_inst.rd(`UIP_ADDR_LSR, v);
    `CHK("line status", 8'hA2, v)
    cause_is(8'hC0);
    uip_host_model_inst.rd(`UIP_ADDR_MSR, v);
    cause_is(8'hC1);
    cfg.auto_rts = 1'b1;
    rts_n_out = 1'b1;
    cause_is(8'hE0);
    uip_host_model_inst.rd(`UIP_ADDR_MSR, v);
    cause_is(8'hC1);
    uip_host_model_inst.wr(`UIP_ADDR_MASK, 8'h80);
    cfg.auto_cts = 1'b1;
    cts_n_pin = 1'b1;
    repeat (4) @(negedge clk);
    cause_is(8'hE0);
    uip_host_model_inst.rd(`UIP_ADDR_MSR, v);
    cause_is(8'hC1);
    cfg.rs485_auto = 1'b1;
    uip_host_model_inst.wr(`UIP_ADDR_MASK, 8'h02);
    evt.tx_all_empty = 1'b1;
    cause_is(8'hC2);
    cause_is(8'hC1);
    $display("test status sources done");
    uip_host_model_inst.wr(`UIP_ADDR_MASK, 8'h21);
    evt.xoff_det = 1'b1;
    @(negedge clk);
    evt.xoff_det = 1'b0;
    cause_is(8'hD0);
    cause_is(8'hC1);
    evt.special_det = 1'b1;
    @(negedge clk);
    evt.special_det = 1'b0;
    cause_is(8'hD0);
    evt.special_det = 1'b1;
    @(negedge clk);
    evt.special_det = 1'b0;
    evt.xon_det = 1'b1;
    @(negedge clk);
    evt.xon_det = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("irq special", 1'b1, irq)
    evt.rx_char_loaded = 1'b1;
    @(negedge clk);
    evt.rx_char_loaded = 1'b0;
    cause_is(8'hC1);
    $display("test flow characters done");
    evt.rx_empty = 1'b0;
    evt.bit_tick = 1'b1;
    repeat (12) @(negedge clk);
    `CHK("irq early", 1'b0, irq)
    repeat (8) @(negedge clk);
    evt.bit_tick = 1'b0;
    cause_is(8'hCC);
    evt.rx_empty = 1'b1;
    cause_is(8'hC1);
    $display("test timeout done");
    tally_and_finish();
  end
endmodule // test_uart_interrupt_prioritizer
